/* rfp_ctrl_model.sv */
`timescale 1ns/100ps
// register bus controller: one strobe per access, answer taken one edge later
module rfp_ctrl_model (
    input  wire logic          clock,
    input  wire logic [15:0]   rdata,
    input  wire logic          ack,
    output rfp_pkg::rfp_bus_t  bus
);
    initial bus = '0;
    // strobes stand one cycle; stale address and data are flipped so they never look valid
    task automatic access(input logic a24, input logic [23:0] addr, input logic wr,
                          input logic [15:0] wdata, output logic [15:0] rd, output logic got);
        @(posedge clock);
        #1;
        bus = '{a24: a24, addr: addr, wr: wr, rd: !wr, wdata: wdata};
        @(posedge clock);
        #1;
        got = ack;
        rd = rdata;
        bus.wr = 1'b0;
        bus.rd = 1'b0;
        bus.addr = ~addr;
        bus.wdata = ~wdata;
    endtask : access
endmodule : rfp_ctrl_model

/* rfp_pkg.sv */
package rfp_pkg;
    // timing: one microsecond in system clocks
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS         = 1000;
    localparam int US_CYCLES     = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // configuration space
    localparam logic [15:0] CFG_BASE = 16'hC000;
    localparam int          LA_SHIFT = 6;
    localparam logic [5:0]  CFG_ID   = 6'h00;
    localparam logic [5:0]  CFG_DT   = 6'h02;
    localparam logic [5:0]  CFG_ST   = 6'h04;
    localparam logic [5:0]  CFG_OFS  = 6'h06;
    localparam logic [5:0]  CFG_ATR  = 6'h08;
    localparam logic [5:0]  CFG_SNH  = 6'h0A;
    localparam logic [5:0]  CFG_SNL  = 6'h0C;
    localparam logic [5:0]  CFG_ISR  = 6'h1A;
    localparam logic [5:0]  CFG_ICR  = 6'h1C;
    // data space, upper part
    localparam logic [7:0] D_FILL = 8'h4E;
    localparam logic [7:0] D_HLTH = 8'h70;
    localparam logic [7:0] D_TSRC = 8'h72;
    localparam logic [7:0] D_FWL  = 8'h74;
    localparam logic [7:0] D_PROM = 8'h76;
    localparam logic [7:0] D_DLY  = 8'h78;
    localparam logic [7:0] D_MASK = 8'h88;
    localparam logic [7:0] D_SET  = 8'h8A;
    localparam logic [7:0] D_TUNE = 8'h9A;
    localparam logic [7:0] D_ARC  = 8'h9C;
    localparam logic [7:0] D_LCLR = 8'h9E;
    localparam logic [7:0] D_NAMH = 8'hA0;
    localparam logic [7:0] D_NAML = 8'hA2;
    // field positions
    localparam int CTL_RST  = 0;
    localparam int CTL_SFI  = 1;
    localparam int CTL_SOFTWARE_IRQ_TEST = 13;
    localparam int CTL_A24  = 15;
    localparam int ICR_EN   = 7;
    localparam int MSK_SOFT = 15;
    localparam int TRG_TUNE = 1;
    localparam int TRG_GATE = 3;
    localparam int TRG_MPS  = 6;
    // reset values and fixed read-back fields
    localparam logic [15:0] ICR_RST  = 16'hFFFF;
    localparam logic [15:0] ZERO_RST = 16'h0000;
    localparam logic [15:0] ATR_VAL  = 16'h0002;
    localparam logic [1:0]  ADR_SPC  = 2'h0;
    localparam logic [1:0]  DEV_CLS  = 2'h1;
    localparam logic [3:0]  MEM_CODE = 4'hF;
    typedef struct packed {
        logic        a24;
        logic [23:0] addr;
        logic        wr;
        logic        rd;
        logic [15:0] wdata;
    } rfp_bus_t;
    typedef struct packed {
        logic [7:0]  la_sw;
        logic [8:0]  rails;
        logic [1:0]  side;
        logic        clk_int;
        logic        hw_permit;
        logic        slot_n;
        logic        test_ok;
        logic        init_ok;
        logic        build_hi;
        logic [7:0]  trig;
        logic [13:0] arc;
        logic [79:0] adc;
    } rfp_pins_t;
endpackage : rfp_pkg

/* rfp_regs.sv */
`timescale 1ns/100ps
module rfp_regs #(
    parameter logic [11:0] MAKER_ID  = 12'h123, // arbitrary value
    parameter logic [11:0] MODEL_ID  = 12'h456, // arbitrary value
    parameter logic [31:0] SERIAL_NO = 32'h0000_0001, // arbitrary
    parameter logic [15:0] FW_LEVEL  = 16'h0001, // arbitrary value
    parameter logic [31:0] NAME_TEXT = 32'h5246_5000 // arbitrary
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire rfp_pkg::rfp_bus_t bus,
    input  wire rfp_pkg::rfp_pins_t pins,
    output logic [15:0]            rdata_reg,
    output logic                   ack_reg,
    output logic                   carrier_permit_reg,
    output logic                   permit_fault_reg,
    output logic [7:0]             fault_reg,
    output logic                   arc_counter_clear_reg,
    output logic [7:0]             local_irq_line_reg,
    output logic                   irq_request_reg,
    output logic [2:0]             irq_level_reg,
    output logic                   sysfail_reg,
    output logic                   module_reset_reg,
    output logic [4:0]             reprogram_page_select_reg,
    output logic [2:0]             image_page_lines_reg,
    output logic                   trace_a_reg,
    output logic                   trace_b_reg
);
    rfp_pkg::rfp_pins_t p1_reg, ps_reg, pd_reg;
    logic [7:0]  la_reg;
    logic        la_loaded_reg;
    logic [15:0] ctrl_reg, offset_reg, icr_reg;
    logic        a24_active_reg;
    logic [15:0] tsrc_reg, prom_reg, mask_reg;
    logic [15:0] fill_time_reg, tune_time_reg;
    logic [15:0] dly_reg [8];
    logic [15:0] set_reg [8];
    logic [7:0]  pend_reg;
    logic [7:0]  pend_next;
    logic [6:0]  us_cnt_reg;
    logic        tick_reg;
    logic [15:0] fill_cnt_reg, blank_cnt_reg;
    logic [15:0] pcnt_reg [8];
    logic [7:0]  fault_next, over, cond;
    logic [15:0] cfg_base;
    logic        hit16, hit24, wr16, wr24, rd_hit;
    logic [7:0]  off;
    logic        gate_fall, tune_fall, fill_done, blanked;
    logic        software_irq_test_fall, lclr, soft_rst;
    logic [31:0] src;
    logic [15:0] rd_mux;
    logic [15:0] health;

    // two-flop synchroniser for every pin; kept out of reset so the switch strap
    // has already passed through it when reset lets go and the address is loaded
    always_ff @(posedge clock) begin
        p1_reg <= pins;
        ps_reg <= p1_reg;
        pd_reg <= ps_reg;
    end

    // address decode; the base moves with the logical address
    assign cfg_base = rfp_pkg::CFG_BASE
                    + (16'(la_reg) << rfp_pkg::LA_SHIFT);
    assign hit16 = !bus.a24 && bus.addr[15:6] == cfg_base[15:6];
    assign hit24 = bus.a24 && a24_active_reg
                 && bus.addr[23:8] == offset_reg;
    assign off   = bus.addr[7:0];
    assign wr16  = hit16 && bus.wr;
    assign wr24  = hit24 && bus.wr && !module_reset_reg;
    assign lclr  = hit24 && (bus.wr || bus.rd) && off == rfp_pkg::D_LCLR;
    assign soft_rst = module_reset_reg;

    // logical address: switch strap after reset, then software
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            la_reg        <= 8'h00;
            la_loaded_reg <= 1'b0;
        end else if (!la_loaded_reg) begin
            la_reg        <= ps_reg.la_sw;
            la_loaded_reg <= 1'b1;
        end else if (wr16 && bus.addr[5:0] == rfp_pkg::CFG_ID) begin
            la_reg <= bus.wdata[7:0];
        end
    end

    // configuration-space control, offset and irq setup
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_reg       <= rfp_pkg::ZERO_RST;
            offset_reg     <= rfp_pkg::ZERO_RST;
            icr_reg        <= rfp_pkg::ICR_RST;
            a24_active_reg <= 1'b0;
        end else if (wr16) begin
            unique case (bus.addr[5:0])
                rfp_pkg::CFG_ST: begin
                    ctrl_reg       <= bus.wdata;
                    a24_active_reg <= bus.wdata[rfp_pkg::CTL_A24];
                end
                rfp_pkg::CFG_OFS: offset_reg <= bus.wdata;
                rfp_pkg::CFG_ICR: icr_reg <= bus.wdata;
                default: ; // read-only offsets ignore writes
            endcase
        end
    end
    assign software_irq_test_fall = wr16 && bus.addr[5:0] == rfp_pkg::CFG_ST
                     && ctrl_reg[rfp_pkg::CTL_SOFTWARE_IRQ_TEST]
                     && !bus.wdata[rfp_pkg::CTL_SOFTWARE_IRQ_TEST];

    // data-space settings; writes are refused while held in reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tsrc_reg      <= rfp_pkg::ZERO_RST;
            prom_reg      <= rfp_pkg::ZERO_RST;
            mask_reg      <= rfp_pkg::ZERO_RST;
            fill_time_reg <= rfp_pkg::ZERO_RST;
            tune_time_reg <= rfp_pkg::ZERO_RST;
        end else if (wr24) begin
            unique case (off)
                rfp_pkg::D_TSRC: tsrc_reg <= bus.wdata;
                rfp_pkg::D_PROM: prom_reg <= {8'h00, bus.wdata[7:0]};
                rfp_pkg::D_MASK: mask_reg <= bus.wdata & 16'h80FF;
                rfp_pkg::D_FILL: fill_time_reg <= bus.wdata;
                rfp_pkg::D_TUNE: tune_time_reg <= bus.wdata;
                default: ;
            endcase
        end
    end

    // per-channel setpoints, persistence and fault maturation
    for (genvar i = 0; i < 8; i++) begin : g_ch
        assign over[i] = 16'(ps_reg.adc[i*10 +: 10]) > set_reg[i];
        assign cond[i] = mask_reg[i] && over[i] && fill_done && !blanked;
        // the first tick may come at once, so one more whole microsecond is counted
        assign fault_next[i] = cond[i]
                             && (dly_reg[i] == 16'h0000 || pcnt_reg[i] > dly_reg[i]);
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                dly_reg[i] <= rfp_pkg::ZERO_RST;
                set_reg[i] <= rfp_pkg::ZERO_RST;
            end else if (wr24 && off == rfp_pkg::D_DLY + 8'(2 * i)) begin
                dly_reg[i] <= bus.wdata;
            end else if (wr24 && off == rfp_pkg::D_SET + 8'(2 * i)) begin
                set_reg[i] <= bus.wdata;
            end
        end
        // counts microsecond ticks while the condition lasts
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                pcnt_reg[i] <= 16'h0000;
                fault_reg[i] <= 1'b0;
            end else if (soft_rst) begin
                pcnt_reg[i] <= 16'h0000;
                fault_reg[i] <= 1'b0;
            end else begin
                if (!cond[i])
                    pcnt_reg[i] <= 16'h0000;
                else if (tick_reg && pcnt_reg[i] != 16'hFFFF)
                    pcnt_reg[i] <= pcnt_reg[i] + 16'h0001;
                if (fault_next[i])
                    fault_reg[i] <= 1'b1;
                else if (lclr)
                    fault_reg[i] <= 1'b0;
            end
        end
    end

    // microsecond tick for every timer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            us_cnt_reg <= 7'h00;
            tick_reg   <= 1'b0;
        end else begin
            tick_reg   <= us_cnt_reg == 7'(rfp_pkg::US_CYCLES - 1);
            us_cnt_reg <= (us_cnt_reg == 7'(rfp_pkg::US_CYCLES - 1))
                        ? 7'h00 : us_cnt_reg + 7'h01;
        end
    end

    // fill window from gate start, blanking from tune trigger fall
    assign gate_fall = pd_reg.trig[rfp_pkg::TRG_GATE] && !ps_reg.trig[rfp_pkg::TRG_GATE];
    assign tune_fall = pd_reg.trig[rfp_pkg::TRG_TUNE] && !ps_reg.trig[rfp_pkg::TRG_TUNE];
    assign fill_done = !ps_reg.trig[rfp_pkg::TRG_GATE] && !gate_fall
                     && fill_cnt_reg == 16'h0000;
    assign blanked   = blank_cnt_reg != 16'h0000;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fill_cnt_reg  <= 16'h0000;
            blank_cnt_reg <= 16'h0000;
        end else begin
            if (gate_fall) // a partial first microsecond must not shorten the window
                fill_cnt_reg <= (&fill_time_reg) ? fill_time_reg
                              : fill_time_reg + 16'h0001;
            else if (tick_reg && fill_cnt_reg != 16'h0000)
                fill_cnt_reg <= fill_cnt_reg - 16'h0001;
            if (tune_fall)
                blank_cnt_reg <= (&tune_time_reg) ? tune_time_reg
                               : tune_time_reg + 16'h0001;
            else if (tick_reg && blanked)
                blank_cnt_reg <= blank_cnt_reg - 16'h0001;
        end
    end

    // local irq lines: channel faults and test bit; set beats clear
    always_comb begin
        pend_next = pend_reg;
        if (lclr)
            pend_next = 8'h00;
        pend_next = pend_next | (fault_next & ~fault_reg);
        if (software_irq_test_fall)
            pend_next[0] = 1'b1;
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            pend_reg <= 8'h00;
        else
            pend_reg <= pend_next;
    end

    // backplane-facing outputs, all registered
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            local_irq_line_reg <= 8'h00;
            irq_request_reg    <= 1'b0;
            irq_level_reg      <= 3'h0;
            sysfail_reg        <= 1'b0;
            module_reset_reg   <= 1'b0;
        end else begin
            local_irq_line_reg <= pend_reg & ~icr_reg[15:8];
            irq_request_reg    <= |(pend_reg & ~icr_reg[15:8])
                                && !icr_reg[rfp_pkg::ICR_EN];
            irq_level_reg      <= icr_reg[5:3];
            sysfail_reg        <= !ps_reg.test_ok && !ctrl_reg[rfp_pkg::CTL_SFI];
            module_reset_reg   <= ctrl_reg[rfp_pkg::CTL_RST];
        end
    end

    // permit, strobes, page lines and trace sources
    assign src = {ps_reg.trig[rfp_pkg::TRG_MPS], ps_reg.hw_permit,
                  ps_reg.arc, over, ps_reg.trig};
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            carrier_permit_reg    <= 1'b0;
            permit_fault_reg      <= 1'b0;
            arc_counter_clear_reg <= 1'b0;
            reprogram_page_select_reg         <= 5'h00;
            image_page_lines_reg  <= 3'h0;
            trace_a_reg           <= 1'b0;
            trace_b_reg           <= 1'b0;
        end else begin
            carrier_permit_reg <= mask_reg[rfp_pkg::MSK_SOFT] && ps_reg.hw_permit
                                && fault_reg == 8'h00;
            permit_fault_reg   <= !mask_reg[rfp_pkg::MSK_SOFT] || !ps_reg.hw_permit;
            arc_counter_clear_reg <= hit24 && (bus.wr || bus.rd)
                                   && off == rfp_pkg::D_ARC;
            reprogram_page_select_reg        <= prom_reg[4:0];
            image_page_lines_reg <= prom_reg[7:5];
            trace_a_reg <= src[tsrc_reg[4:0]];
            trace_b_reg <= src[tsrc_reg[12:8]];
        end
    end

    // read multiplexer; unmapped offsets read zero; unused ICR bits 0-2 and 6 and health bit 15 read one
    assign health = {1'b1, ps_reg.clk_int, ps_reg.rails,
                     ps_reg.side, 3'h0};
    assign rd_hit = bus.rd && (hit16 || hit24);
    always_comb begin
        rd_mux = 16'h0000;
        if (hit16) begin
            unique case (bus.addr[5:0])
                rfp_pkg::CFG_ID:  rd_mux = {rfp_pkg::DEV_CLS, rfp_pkg::ADR_SPC,
                                            MAKER_ID};
                rfp_pkg::CFG_DT:  rd_mux = {rfp_pkg::MEM_CODE, MODEL_ID};
                rfp_pkg::CFG_ST:  rd_mux = {a24_active_reg, ps_reg.slot_n, 10'h000,
                                            ps_reg.init_ok, ps_reg.test_ok, 1'b0,
                                            ps_reg.build_hi};
                rfp_pkg::CFG_OFS: rd_mux = offset_reg;
                rfp_pkg::CFG_ATR: rd_mux = rfp_pkg::ATR_VAL;
                rfp_pkg::CFG_SNH: rd_mux = SERIAL_NO[31:16];
                rfp_pkg::CFG_SNL: rd_mux = SERIAL_NO[15:0];
                rfp_pkg::CFG_ISR: rd_mux = {pend_reg, 8'h00};
                rfp_pkg::CFG_ICR: rd_mux = icr_reg | 16'h0047;
                default: rd_mux = 16'h0000;
            endcase
        end else if (hit24) begin
            unique case (off)
                rfp_pkg::D_HLTH: rd_mux = health;
                rfp_pkg::D_TSRC: rd_mux = tsrc_reg;
                rfp_pkg::D_FWL:  rd_mux = FW_LEVEL;
                rfp_pkg::D_PROM: rd_mux = prom_reg;
                rfp_pkg::D_MASK: rd_mux = mask_reg;
                rfp_pkg::D_FILL: rd_mux = fill_time_reg;
                rfp_pkg::D_TUNE: rd_mux = tune_time_reg;
                rfp_pkg::D_NAMH: rd_mux = NAME_TEXT[31:16];
                rfp_pkg::D_NAML: rd_mux = NAME_TEXT[15:0];
                default: rd_mux = 16'h0000;
            endcase
            for (int k = 0; k < 8; k++) begin
                if (off == rfp_pkg::D_DLY + 8'(2 * k))
                    rd_mux = dly_reg[k];
                if (off == rfp_pkg::D_SET + 8'(2 * k))
                    rd_mux = set_reg[k];
            end
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_reg <= 16'h0000;
            ack_reg   <= 1'b0;
        end else begin
            rdata_reg <= rd_hit ? rd_mux : 16'h0000;
            ack_reg   <= rd_hit || (bus.wr && (hit16 || hit24));
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_arc_wr;
        hit24 && bus.wr && off == rfp_pkg::D_ARC;
    endsequence
    sequence s_pulse;
        arc_counter_clear_reg ##1 !arc_counter_clear_reg;
    endsequence

    health_read_a: assert property (bus.rd && hit24 && off == rfp_pkg::D_HLTH
        |=> rdata_reg[15] && rdata_reg[14:3] == $past(health[14:3]))
        else $error("health word wrong");
    persist_hold_a: assert property ($rose(fault_reg[0]) && !$past(soft_rst)
        |-> $past(cond[0]) && $past(pcnt_reg[0]) >= $past(dly_reg[0]))
        else $error("fault set without persistence");
    mask_gate_a: assert property (!mask_reg[2] && !fault_reg[2]
        |=> !fault_reg[2])
        else $error("masked channel faulted");
    permit_and_a: assert property (carrier_permit_reg
        |-> $past(mask_reg[rfp_pkg::MSK_SOFT] && ps_reg.hw_permit))
        else $error("permit without both sources");
    tune_blank_a: assert property (tune_fall && tune_time_reg != 16'h0000
        |=> blanked && cond == 8'h00)
        else $error("tune blanking missing");
    arc_clear_a: assert property (s_arc_wr |=> s_pulse)
        else $error("arc clear strobe wrong");
    irq_clear_a: assert property (lclr && !software_irq_test_fall && fault_next == 8'h00
        |=> pend_reg == 8'h00 ##1 irq_request_reg == 1'b0)
        else $error("irq clear failed");
    software_irq_test_irq_a: assert property (software_irq_test_fall |=> pend_reg[0])
        else $error("test irq missing");
    isr_keep_a: assert property (bus.rd && hit16 && bus.addr[5:0] == rfp_pkg::CFG_ISR
        && !lclr |=> (pend_reg & $past(pend_reg)) == $past(pend_reg))
        else $error("status read cleared irq");
    a24_gate_a: assert property ($rose(a24_active_reg)
        |-> $past(wr16 && bus.wdata[rfp_pkg::CTL_A24]))
        else $error("wide space enabled without control");
endmodule : rfp_regs

/* tb.sv */
`timescale 1ns/100ps
module tb;
    localparam logic [7:0] LA = 8'h05;
    logic clock, rst, ak, acl, crp, pft, irq, sf, mrs, ta, tb_b;
    logic [15:0] rdata, rv;
    logic ack;
    logic [7:0] flt, local_irq_line;
    logic [4:0] pa;
    logic [2:0] lvl, img;
    int failures = 0;
    int n_checks = 0;
    rfp_pkg::rfp_bus_t  bus;
    rfp_pkg::rfp_pins_t pins;
    rfp_regs rfp_regs_inst (.clock(clock), .rst(rst), .bus(bus), .pins(pins), .rdata_reg(rdata),
        .ack_reg(ack), .carrier_permit_reg(crp), .permit_fault_reg(pft), .fault_reg(flt),
        .arc_counter_clear_reg(acl), .local_irq_line_reg(local_irq_line), .irq_request_reg(irq),
        .irq_level_reg(lvl), .sysfail_reg(sf), .module_reset_reg(mrs), .reprogram_page_select_reg(pa),
        .image_page_lines_reg(img), .trace_a_reg(ta), .trace_b_reg(tb_b));
    rfp_ctrl_model rfp_ctrl_model_inst (.clock(clock), .rdata(rdata), .ack(ack), .bus(bus));
    // clock, and a watchdog sized well above the under two thousand cycles the tests need
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        #200000;
        failures++;
        conclude();
    end
    task automatic conclude();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    function automatic logic [23:0] adr(input logic a, input logic [7:0] o);
        return a ? {16'h0012, o} : {8'h00, rfp_pkg::CFG_BASE + ({8'h00, LA} << 6) + {8'h00, o}};
    endfunction : adr
    task automatic wr(input logic a, input logic [7:0] o, input logic [15:0] v);
        rfp_ctrl_model_inst.access(a, adr(a, o), 1'b1, v, rv, ak);
        check({15'h0000, ak}, 16'h0001);
    endtask : wr
    task automatic rd(input logic a, input logic [7:0] o, input logic [15:0] e);
        rfp_ctrl_model_inst.access(a, adr(a, o), 1'b0, 16'h0000, rv, ak);
        check({15'h0000, ak}, 16'h0001);
        check(rv, e);
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc
    // main sequence; pins stay steady well before reset lets go
    initial begin
        rst = 1'b1;
        pins = '{la_sw: LA, rails: 9'h1A5, side: 2'h2, clk_int: 1'b1, hw_permit: 1'b1,
                 slot_n: 1'b0, test_ok: 1'b0, init_ok: 1'b1, build_hi: 1'b1, trig: 8'hBF,
                 arc: 14'h0000, adc: '0};
        cyc(4);
        rst = 1'b0;
        cyc(2);
        rd(1'b0, 8'h00, {rfp_pkg::DEV_CLS, rfp_pkg::ADR_SPC, 12'h123});
        rd(1'b0, 8'h02, {rfp_pkg::MEM_CODE, 12'h456});
        rfp_ctrl_model_inst.access(1'b0, 24'h00C180, 1'b0, 16'h0000, rv, ak);
        check({15'h0000, ak}, 16'h0000);
        rfp_ctrl_model_inst.access(1'b1, adr(1'b1, 8'h70), 1'b0, 16'h0000, rv, ak);
        check({15'h0000, ak}, 16'h0000);
        $display("identity test done");
        wr(1'b0, 8'h06, 16'h0012);
        rd(1'b0, 8'h06, 16'h0012);
        wr(1'b0, 8'h04, 16'h8000);
        rd(1'b0, 8'h04, 16'h8009);
        check({15'h0000, sf}, 16'h0001);
        wr(1'b0, 8'h04, 16'h8003);
        cyc(1);
        check({14'h0000, mrs, sf}, 16'h0002);
        wr(1'b0, 8'h04, 16'h8002);
        $display("control test done");
        wr(1'b1, 8'h70, 16'h0000);
        rd(1'b1, 8'h70, {2'h3, 9'h1A5, 2'h2, 3'h0});
        wr(1'b1, 8'h76, 16'hFFFF);
        rd(1'b1, 8'h76, 16'h00FF);
        check({8'h00, img, pa}, 16'h00FF);
        wr(1'b1, 8'h72, 16'h1E1F);
        cyc(2);
        check({14'h0000, ta, tb_b}, 16'h0001);
        wr(1'b1, 8'h72, 16'h1F1E);
        cyc(2);
        check({14'h0000, ta, tb_b}, 16'h0002);
        $display("data register test done");
        wr(1'b0, 8'h1C, 16'hFE08);
        rd(1'b0, 8'h1C, 16'hFE4F);
        check({13'h0000, lvl}, 16'h0001);
        wr(1'b0, 8'h04, 16'hA002);
        wr(1'b0, 8'h04, 16'h8002);
        cyc(2);
        check({7'h00, irq, local_irq_line}, 16'h0101);
        rd(1'b0, 8'h1A, 16'h0100);
        rd(1'b0, 8'h1A, 16'h0100);
        wr(1'b1, 8'h9E, 16'h0000);
        cyc(1);
        check({7'h00, irq, local_irq_line}, 16'h0000);
        $display("interrupt test done");
        wr(1'b1, 8'h88, 16'h80FF);
        rd(1'b1, 8'h88, 16'h80FF);
        wr(1'b1, 8'h8A, 16'h0064);
        rd(1'b1, 8'h8A, 16'h0064);
        wr(1'b1, 8'h78, 16'h0002);
        wr(1'b1, 8'h4E, 16'h0001);
        cyc(4);
        check({14'h0000, crp, pft}, 16'h0002);
        pins.trig[3] = 1'b0;
        pins.adc[9:0] = 10'h0C8;
        cyc(250);
        check({8'h00, flt}, 16'h0000);
        cyc(300);
        check({7'h00, crp, flt}, 16'h0001);
        check({8'h00, local_irq_line}, 16'h0001);
        pins.adc[9:0] = 10'h000;
        cyc(2);
        wr(1'b1, 8'h9E, 16'h0000);
        cyc(1);
        check({7'h00, flt, local_irq_line[0]}, 16'h0000);
        wr(1'b1, 8'h88, 16'h00FF);
        cyc(2);
        check({14'h0000, crp, pft}, 16'h0001);
        $display("fault test done");
        wr(1'b1, 8'h9A, 16'h0005);
        pins.trig[1] = 1'b0;
        pins.adc[9:0] = 10'h0C8;
        cyc(400);
        check({8'h00, flt}, 16'h0000);
        cyc(600);
        check({8'h00, flt}, 16'h0001);
        $display("tune blanking test done");
        wr(1'b1, 8'h9C, 16'h0000);
        check({15'h0000, acl}, 16'h0001);
        cyc(1);
        check({15'h0000, acl}, 16'h0000);
        $display("arc clear test done");
        conclude();
    end
endmodule : tb
